// [core/port_global_config.sv]
// global port-bank configuration block with two external interrupts
// What this block does
// - mode 10 flags both edges and ignores polarity.
// - mode 00 detects pin level, sense set by polarity.
// - mode 01 detects one edge type per polarity; 11 reserved.
// - polarity 0 means low or falling, 1 means high or rising.
// - channel enables at bit 7 and bit 15.
// - four-bit pin selects at 3:0 and 11:8 pick one of 16.
// - channel a banks 0 and 1, channel b banks 2 and 3.
// - pin selection only observes, never affects crossbar routing.
// - edge modes set pending once per qualifying edge.
// - level mode pending follows the active input level.
// - done flag resets to 1, cleared by phase write, set on expiry.
// - while busy, masked latch and phase bits ignore writes.
// - bits 28:24 hold the pulse delay count.
// - lock bit blocks writes to control b, crossbar, skip registers.
// - bit 9 enables pin compare logic; no register access depends on it.
// - bit 12 selects low power timer output pin.
// - bit 8 connects second SPI unit to fixed pins.
// - bits 0,1,2 pin out scan, trace, viewer; scan resets 1.
// - bit 31 enables crossbar a, reset 0.
// - bits 22,21,20 route clock/16, converter trigger, timer input.
// - base plus 4 sets bits, base plus 8 clears bits, for control a, control b and crossbar only.
`timescale 1ns/10ps
`default_nettype none
module port_global_config
   import port_cfg_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   // port bank pins observed by the interrupt channels
   input wire logic [11:0] bank0_pins,
   input wire logic [3:0] bank1_pins,
   input wire logic [7:0] bank2_pins,
   input wire logic [7:0] bank3_pins,
   // interrupt requests
   output logic ext_irq_chan_a,
   output logic ext_irq_chan_b,
   // routing and configuration outputs
   output logic [15:0] bank_zero_output_latch,
   output logic [15:0] crossbar_skip_mask,
   output logic pin_compare_enable,
   output logic lowpower_timer_out_select,
   output logic spi_b_fixed_pins,
   output logic scan_port_pinout,
   output logic trace_port_pinout,
   output logic wire_viewer_pinout,
   output logic crossbar_a_enable,
   output logic bus_clock_div_out_enable,
   output logic converter_trigger_route,
   output logic timer_b_ext_input_route,
   output logic [19:0] crossbar_a_low_enables
);
   // ------------------------------------------
   // state
   // ------------------------------------------
   logic [31:0] ctrl_a_reg, ctrl_a_next;
   logic [31:0] ctrl_b_reg, ctrl_b_next;
   logic [31:0] xbar_reg, xbar_next;
   logic [31:0] phase_reg, phase_next;
   logic [15:0] latch_reg, latch_next;
   logic [15:0] pgmask_reg, pgmask_next;
   logic [15:0] skip_reg, skip_next;
   logic [4:0] tmr_reg, tmr_next;
   logic [1:0] key_reg, key_next;
   logic [31:0] rdata_reg, rdata_next;

   // decoded write kinds
   logic [31:0] base;
   logic is_set, is_clr, is_all;
   logic wr_ca, wr_cb, wr_xb, wr_key, wr_ph, wr_lt, wr_pm, wr_sk;
   logic locked, busy;

   // ------------------------------------------
   // address decode
   // ------------------------------------------
   function automatic logic [31:0] apply(input logic [31:0] cur, input logic [31:0] wd,
                                        input logic s, input logic c);
      logic [31:0] r;
      r = wd;
      if (s) begin
         r = cur | wd;
      end else if (c) begin
         r = cur & ~wd;
      end
      return r;
   endfunction

   always_comb begin
      is_set = 1'b0;
      is_clr = 1'b0;
      base = reg_addr;
      if ((reg_addr & 32'h0000000F) == OFS_SET) begin
         is_set = 1'b1;
         base = reg_addr - OFS_SET;
      end else if ((reg_addr & 32'h0000000F) == OFS_CLR) begin
         is_clr = 1'b1;
         base = reg_addr - OFS_CLR;
      end
      is_all = ~is_set & ~is_clr;
      wr_ca = reg_wr && base == ADDR_CTRL_A;
      wr_cb = reg_wr && base == ADDR_CTRL_B;
      wr_xb = reg_wr && base == ADDR_XBAR_A;
      wr_key = reg_wr && is_all && base == ADDR_KEY;
      wr_ph = reg_wr && is_all && base == ADDR_PHASE;
      wr_lt = reg_wr && is_all && base == ADDR_LATCH;
      wr_pm = reg_wr && is_all && base == ADDR_PGMASK;
      wr_sk = reg_wr && is_all && base == ADDR_SKIP;
   end

   // lock applies only while lock bit set and not opened by the key
   assign locked = ctrl_b_reg[POS_LOCK] && key_reg != LOCK_STAT_OPEN;
   assign busy = ~ctrl_a_reg[POS_DONE];

   // ------------------------------------------
   // lock key sequencing
   // ------------------------------------------
   always_comb begin
      key_next = key_reg;
      if (wr_key) begin
         if (key_reg == LOCK_STAT_OPEN) begin
            key_next = LOCK_STAT_NONE;
         end else if (key_reg == LOCK_STAT_NONE && reg_wdata[7:0] == KEY_FIRST) begin
            key_next = LOCK_STAT_ONE;
         end else if (key_reg == LOCK_STAT_ONE && reg_wdata[7:0] == KEY_SECOND) begin
            key_next = LOCK_STAT_OPEN;
         end else begin
            key_next = LOCK_STAT_NONE;
         end
      end else if ((wr_cb || wr_xb || wr_sk) && key_reg == LOCK_STAT_OPEN) begin
         key_next = LOCK_STAT_NONE;
      end
   end

   // ------------------------------------------
   // control registers
   // ------------------------------------------
   // the lock write itself is allowed through when unlocked
   always_comb begin
      ctrl_a_next = ctrl_a_reg;
      ctrl_b_next = ctrl_b_reg;
      xbar_next = xbar_reg;
      skip_next = skip_reg;
      pgmask_next = pgmask_reg;
      if (wr_ca) begin
         ctrl_a_next = (apply(ctrl_a_reg, reg_wdata, is_set, is_clr) & CTRL_A_RW_MASK)
                       | (ctrl_a_reg & ~CTRL_A_RW_MASK);
      end
      if (wr_cb && !locked) begin
         ctrl_b_next = apply(ctrl_b_reg, reg_wdata, is_set, is_clr) & CTRL_B_RW_MASK;
      end
      if (wr_xb && !locked) begin
         xbar_next = apply(xbar_reg, reg_wdata, is_set, is_clr) & XBAR_RW_MASK;
      end
      if (wr_sk && !locked) begin
         skip_next = reg_wdata[15:0];
      end
      if (wr_pm) begin
         pgmask_next = reg_wdata[15:0];
      end
      // done flag: expiry wins over a phase write landing in the same cycle
      if (busy && tmr_reg == 5'h00) begin
         ctrl_a_next[POS_DONE] = 1'b1;
      end else if (wr_ph) begin
         ctrl_a_next[POS_DONE] = 1'b0;
      end
   end

   // ------------------------------------------
   // pulse generator
   // ------------------------------------------
   // delay is count plus one cycles, loaded at the phase write
   always_comb begin
      phase_next = phase_reg;
      latch_next = latch_reg;
      tmr_next = tmr_reg;
      // a busy phase write never restarts the timer
      // and must not swallow the phase 1 update at expiry
      if (wr_ph && !busy) begin
         phase_next = reg_wdata;
         latch_next = (reg_wdata[15:0] & pgmask_reg) | (latch_reg & ~pgmask_reg);
         tmr_next = ctrl_a_reg[POS_TMR_HI:POS_TMR_LO];
      end else if (busy) begin
         if (wr_ph) begin
            phase_next = (reg_wdata & ~{pgmask_reg, pgmask_reg})
                         | (phase_reg & {pgmask_reg, pgmask_reg});
         end
         if (tmr_reg == 5'h00) begin
            latch_next = (phase_reg[31:16] & pgmask_reg) | (latch_reg & ~pgmask_reg);
         end else begin
            tmr_next = tmr_reg - 5'h01;
         end
      end
      if (wr_lt) begin
         if (busy) begin
            latch_next = (reg_wdata[15:0] & ~pgmask_reg) | (latch_next & pgmask_reg);
         end else begin
            latch_next = reg_wdata[15:0];
         end
      end
   end

   // ------------------------------------------
   // read path
   // ------------------------------------------
   always_comb begin
      rdata_next = 32'h00000000;
      if (reg_rd) begin
         unique case (reg_addr)
            ADDR_CTRL_A: rdata_next = ctrl_a_reg;
            ADDR_CTRL_B: rdata_next = ctrl_b_reg;
            ADDR_XBAR_A: rdata_next = xbar_reg;
            ADDR_KEY: rdata_next = {30'h0, key_reg};
            ADDR_PHASE: rdata_next = phase_reg;
            ADDR_LATCH: rdata_next = {16'h0000, latch_reg};
            ADDR_PGMASK: rdata_next = {16'h0000, pgmask_reg};
            ADDR_SKIP: rdata_next = {16'h0000, skip_reg};
            default: rdata_next = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_a_reg <= CTRL_A_RESET;
         ctrl_b_reg <= CTRL_B_RESET;
         xbar_reg <= XBAR_RESET;
         phase_reg <= 32'h00000000;
         latch_reg <= LATCH_RESET;
         pgmask_reg <= 16'h0000;
         skip_reg <= 16'h0000;
         tmr_reg <= 5'h00;
         key_reg <= LOCK_STAT_NONE;
         rdata_reg <= 32'h00000000;
      end else begin
         ctrl_a_reg <= ctrl_a_next;
         ctrl_b_reg <= ctrl_b_next;
         xbar_reg <= xbar_next;
         phase_reg <= phase_next;
         latch_reg <= latch_next;
         pgmask_reg <= pgmask_next;
         skip_reg <= skip_next;
         tmr_reg <= tmr_next;
         key_reg <= key_next;
         rdata_reg <= rdata_next;
      end
   end

   // ------------------------------------------
   // interrupt channels
   // ------------------------------------------
   ext_irq_detect u_chan_a (
      .clk(clk),
      .rst_b(rst_b),
      .cand_pins({bank1_pins, bank0_pins}),
      .enable(ctrl_a_reg[POS_A_EN]),
      .detect_mode(ctrl_a_reg[POS_A_MD+1:POS_A_MD]),
      .polarity(ctrl_a_reg[POS_A_POL]),
      .pin_select(ctrl_a_reg[POS_A_SEL+3:POS_A_SEL]),
      .pending(ext_irq_chan_a)
   );

   ext_irq_detect u_chan_b (
      .clk(clk),
      .rst_b(rst_b),
      .cand_pins({bank3_pins, bank2_pins}),
      .enable(ctrl_a_reg[POS_B_EN]),
      .detect_mode(ctrl_a_reg[POS_B_MD+1:POS_B_MD]),
      .polarity(ctrl_a_reg[POS_B_POL]),
      .pin_select(ctrl_a_reg[POS_B_SEL+3:POS_B_SEL]),
      .pending(ext_irq_chan_b)
   );

   // ------------------------------------------
   // outputs
   // ------------------------------------------
   assign reg_rdata = rdata_reg;
   assign bank_zero_output_latch = latch_reg;
   assign crossbar_skip_mask = skip_reg;
   assign pin_compare_enable = ctrl_b_reg[POS_PM_EN];
   assign lowpower_timer_out_select = ctrl_b_reg[POS_LPT_SEL];
   assign spi_b_fixed_pins = ctrl_b_reg[POS_SPI_B];
   assign scan_port_pinout = ctrl_b_reg[POS_SCAN];
   assign trace_port_pinout = ctrl_b_reg[POS_TRACE];
   assign wire_viewer_pinout = ctrl_b_reg[POS_SWV];
   assign crossbar_a_enable = xbar_reg[POS_XBAR_EN];
   assign bus_clock_div_out_enable = xbar_reg[22];
   assign converter_trigger_route = xbar_reg[21];
   assign timer_b_ext_input_route = xbar_reg[20];
   assign crossbar_a_low_enables = xbar_reg[19:0];
endmodule // port_global_config
`default_nettype wire

// [core/port_cfg_pkg.sv]
// constants shared by the port global configuration block
package port_cfg_pkg;
   // ----------------------------------------
   // register addresses (ALL, SET, CLR)
   // ----------------------------------------
   localparam logic [31:0] ADDR_CTRL_A = 32'h4002A000;
   localparam logic [31:0] ADDR_CTRL_B = 32'h4002A010;
   localparam logic [31:0] ADDR_XBAR_A = 32'h4002A020;
   localparam logic [31:0] ADDR_KEY = 32'h4002A030;
   localparam logic [31:0] ADDR_PHASE = 32'h4002A040;
   localparam logic [31:0] ADDR_LATCH = 32'h4002A050;
   localparam logic [31:0] ADDR_PGMASK = 32'h4002A060;
   localparam logic [31:0] ADDR_SKIP = 32'h4002A070;
   localparam logic [31:0] OFS_SET = 32'h00000004;
   localparam logic [31:0] OFS_CLR = 32'h00000008;
   // ----------------------------------------
   // global_control_a fields
   // ----------------------------------------
   localparam int POS_DONE = 31;
   localparam int POS_TMR_HI = 28;
   localparam int POS_TMR_LO = 24;
   localparam int POS_B_EN = 15;
   localparam int POS_B_MD = 13;
   localparam int POS_B_POL = 12;
   localparam int POS_B_SEL = 8;
   localparam int POS_A_EN = 7;
   localparam int POS_A_MD = 5;
   localparam int POS_A_POL = 4;
   localparam int POS_A_SEL = 0;
   localparam logic [31:0] CTRL_A_RW_MASK = 32'h1F00FFFF;
   localparam logic [31:0] CTRL_A_RESET = 32'h80000000;
   // ----------------------------------------
   // global_control_b fields
   // ----------------------------------------
   localparam int POS_LOCK = 31;
   localparam int POS_LPT_SEL = 12;
   localparam int POS_PM_EN = 9;
   localparam int POS_SPI_B = 8;
   localparam int POS_SWV = 2;
   localparam int POS_TRACE = 1;
   localparam int POS_SCAN = 0;
   localparam logic [31:0] CTRL_B_RW_MASK = 32'h80001307;
   localparam logic [31:0] CTRL_B_RESET = 32'h00000001;
   // ----------------------------------------
   // crossbar_a_routing fields
   // ----------------------------------------
   localparam int POS_XBAR_EN = 31;
   localparam logic [31:0] XBAR_RW_MASK = 32'h807FFFFF;
   localparam logic [31:0] XBAR_RESET = 32'h00000000;
   // ----------------------------------------
   // detect modes, keys, lock states
   // ----------------------------------------
   typedef enum logic [1:0] {
      MODE_LEVEL = 2'h0,
      MODE_EDGE = 2'h1,
      MODE_BOTH = 2'h2,
      MODE_RSVD = 2'h3
   } detect_mode_t;
   localparam logic [7:0] KEY_FIRST = 8'hA5;
   localparam logic [7:0] KEY_SECOND = 8'hF1;
   localparam logic [1:0] LOCK_STAT_NONE = 2'h0;
   localparam logic [1:0] LOCK_STAT_ONE = 2'h1;
   localparam logic [1:0] LOCK_STAT_OPEN = 2'h2;
   localparam int LATCH_W = 16;
   localparam logic [15:0] LATCH_RESET = 16'hFFFF;
   localparam int TMR_W = 5;
endpackage

// [core/ext_irq_detect.sv]
// one external interrupt channel: pin select, sync and detection
`timescale 1ns/10ps
`default_nettype none
module ext_irq_detect
   import port_cfg_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // candidate pins, asynchronous
   input wire logic [15:0] cand_pins,
   // configuration
   input wire logic enable,
   input wire logic [1:0] detect_mode,
   input wire logic polarity,
   input wire logic [3:0] pin_select,
   // result
   output logic pending
);
   logic sync1_reg, sync1_next;
   logic sync2_reg, sync2_next;
   logic prev_reg, prev_next;
   logic pend_reg, pend_next;
   logic act_lvl;

   // ------------------------------------------
   // detection
   // ------------------------------------------
   // select only observes the pin, never drives it
   always_comb begin
      sync1_next = cand_pins[pin_select];
      sync2_next = sync1_reg;
      prev_next = sync2_reg;
      act_lvl = polarity ? sync2_reg : ~sync2_reg;
      pend_next = 1'b0;
      // a select change can look like an edge; software should re-arm
      if (enable) begin
         unique case (detect_mode)
            MODE_LEVEL: pend_next = act_lvl;
            MODE_EDGE: pend_next = (sync2_reg != prev_reg) && act_lvl;
            MODE_BOTH: pend_next = sync2_reg != prev_reg;
            MODE_RSVD: pend_next = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         prev_reg <= 1'b0;
         pend_reg <= 1'b0;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         prev_reg <= prev_next;
         pend_reg <= pend_next;
      end
   end

   assign pending = pend_reg; // one cycle per qualifying edge in modes 01 and 10, follows the level in 00
endmodule // ext_irq_detect
`default_nettype wire

// [tb/port_global_config_sva.sv]
// assertion checker for the port global configuration block
`timescale 1ns/10ps
`default_nettype none
module port_global_config_sva
   import port_cfg_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   // pins and requests
   input wire logic [11:0] bank0_pins,
   input wire logic [3:0] bank1_pins,
   input wire logic [7:0] bank2_pins,
   input wire logic [7:0] bank3_pins,
   input wire logic ext_irq_chan_a,
   input wire logic ext_irq_chan_b,
   // routing outputs
   input wire logic [15:0] crossbar_skip_mask,
   input wire logic pin_compare_enable,
   input wire logic lowpower_timer_out_select,
   input wire logic spi_b_fixed_pins,
   input wire logic scan_port_pinout,
   input wire logic trace_port_pinout,
   input wire logic wire_viewer_pinout,
   input wire logic crossbar_a_enable,
   input wire logic bus_clock_div_out_enable,
   input wire logic converter_trigger_route,
   input wire logic timer_b_ext_input_route
);
   // ----
   // shadow of control a and pin history
   // ----
   logic [31:0] sh;
   logic [2:0] age;
   logic [3:0] ha;
   logic [3:0] hb;
   wire logic [15:0] cand_a = {bank1_pins, bank0_pins};
   wire logic [15:0] cand_b = {bank3_pins, bank2_pins};
   wire logic [31:0] wm = reg_wdata & CTRL_A_RW_MASK;
   wire logic hit = reg_wr && reg_addr[31:4] == ADDR_CTRL_A[31:4];
   // age guards against spurious edges right after a select change
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sh <= CTRL_A_RESET;
         age <= 3'h0;
         ha <= 4'h0;
         hb <= 4'h0;
      end else begin
         ha <= {ha[2:0], cand_a[sh[3:0]]};
         hb <= {hb[2:0], cand_b[sh[11:8]]};
         age <= (age == 3'h7) ? age : age + 3'h1;
         if (hit) begin
            age <= 3'h0;
            case (reg_addr[3:0])
               4'h0: sh <= wm | (sh & ~CTRL_A_RW_MASK);
               4'h4: sh <= sh | wm;
               4'h8: sh <= sh & ~wm;
               default: age <= 3'h0;
            endcase
         end
      end
   end
   // pending expected from pin seen three and four edges back
   function automatic logic exp_f(logic [1:0] m, logic p, logic en, logic n, logic o);
      case (m)
         2'h0: return en && n == p;
         2'h1: return en && n != o && n == p;
         2'h2: return en && n != o;
         default: return 1'b0;
      endcase
   endfunction
   // ----
   // assertions
   // ----
   default clocking dclk @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_settled;
      age == 3'h7;
   endsequence
   sequence s_quiet(logic [27:0] base);
      !(reg_wr && reg_addr[31:4] == base);
   endsequence
   a_chan_a_match: assert property (
      s_settled |-> ext_irq_chan_a == exp_f(sh[6:5], sh[4], sh[7], ha[2], ha[3]))
      else $error("chan a pending wrong");
   a_chan_b_match: assert property (
      s_settled |-> ext_irq_chan_b == exp_f(sh[14:13], sh[12], sh[15], hb[2], hb[3]))
      else $error("chan b pending wrong");
   a_chan_a_off: assert property (
      (!sh[POS_A_EN]) [*4] |-> !ext_irq_chan_a)
      else $error("chan a off but raised");
   a_chan_b_rsvd: assert property (
      (sh[14:13] == 2'h3) [*4] |-> !ext_irq_chan_b)
      else $error("reserved mode raised");
   a_ctrla_readback: assert property (
      reg_rd && !reg_wr && reg_addr == ADDR_CTRL_A |=> reg_rdata[28:0] == $past(sh[28:0]))
      else $error("control a readback");
   a_ctrlb_quiet: assert property (
      s_quiet(ADDR_CTRL_B[31:4]) |=> $stable({pin_compare_enable, lowpower_timer_out_select,
      spi_b_fixed_pins, scan_port_pinout, trace_port_pinout, wire_viewer_pinout}))
      else $error("control b moved unwritten");
   a_xbar_quiet: assert property (
      s_quiet(ADDR_XBAR_A[31:4]) |=> $stable({crossbar_a_enable, bus_clock_div_out_enable,
      converter_trigger_route, timer_b_ext_input_route}))
      else $error("crossbar moved unwritten");
   a_skip_quiet: assert property (
      s_quiet(ADDR_SKIP[31:4]) |=> $stable(crossbar_skip_mask))
      else $error("skip mask moved unwritten");
endmodule // port_global_config_sva
bind port_global_config port_global_config_sva chk_u (
   .clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .bank0_pins,
   .bank1_pins, .bank2_pins, .bank3_pins, .ext_irq_chan_a, .ext_irq_chan_b,
   .crossbar_skip_mask, .pin_compare_enable, .lowpower_timer_out_select,
   .spi_b_fixed_pins, .scan_port_pinout, .trace_port_pinout, .wire_viewer_pinout,
   .crossbar_a_enable, .bus_clock_div_out_enable, .converter_trigger_route,
   .timer_b_ext_input_route);
`default_nettype wire

// [tb/pin_source.sv]
// behavioural source of the port bank pin levels
`timescale 1ns/10ps
`default_nettype none
module pin_source (
   // clock
   input wire logic clk,
   // wanted levels and settling lag in cycles
   input wire logic [31:0] target,
   input wire logic [1:0] lag,
   // pin levels
   output logic [11:0] bank0_pins,
   output logic [3:0] bank1_pins,
   output logic [7:0] bank2_pins,
   output logic [7:0] bank3_pins
);
   logic [31:0] pins = 32'hFFFFFFFF;
   logic [1:0] wait_cnt = 2'h0;
   // a slow source lags, then holds the level until asked to change
   always @(posedge clk) begin
      if (pins !== target && wait_cnt >= lag) begin
         pins <= target;
         wait_cnt <= 2'h0;
      end else if (pins !== target) begin
         wait_cnt <= wait_cnt + 2'h1;
      end
   end
   assign {bank3_pins, bank2_pins, bank1_pins, bank0_pins} = pins;
endmodule // pin_source
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the port global configuration block
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import port_cfg_pkg::*;
;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_addr = 32'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic [31:0] tgt = 32'hFFFFFFFF;
   logic [1:0] lag = 2'h0;
   logic [31:0] reg_rdata, rv;
   logic [11:0] b0;
   logic [3:0] b1;
   logic [7:0] b2, b3;
   logic irq_a, irq_b, pm, lpt, spi, scan, trc, swv, xen, ahb, adc, tmr;
   logic [15:0] latch, skip;
   logic [19:0] xlow;
   int fails = 0, total_checks = 0, seed = 96, cyc = 0;
   always #5 clk = ~clk;
   pin_source src_u (.clk, .target(tgt), .lag, .bank0_pins(b0),
      .bank1_pins(b1), .bank2_pins(b2), .bank3_pins(b3));
   port_global_config dut_u (.clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
      .bank0_pins(b0), .bank1_pins(b1), .bank2_pins(b2), .bank3_pins(b3),
      .ext_irq_chan_a(irq_a), .ext_irq_chan_b(irq_b), .bank_zero_output_latch(latch),
      .crossbar_skip_mask(skip), .pin_compare_enable(pm), .lowpower_timer_out_select(lpt),
      .spi_b_fixed_pins(spi), .scan_port_pinout(scan), .trace_port_pinout(trc),
      .wire_viewer_pinout(swv), .crossbar_a_enable(xen), .bus_clock_div_out_enable(ahb),
      .converter_trigger_route(adc), .timer_b_ext_input_route(tmr),
      .crossbar_a_low_enables(xlow));
   // ----
   // shared tasks and expectations
   // ----
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // hang guard, the full run needs about 1400 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails = fails + 1;
         end_of_test();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [31:0] a, d);
      @(posedge clk);
      #1 reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clk);
      #1 reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [31:0] a);
      @(posedge clk);
      #1 reg_rd = 1'b1;
      reg_addr = a;
      @(posedge clk);
      #1 reg_rd = 1'b0;
      rv = reg_rdata;
   endtask
   // pulses after one pin change, or final level when lvl is set
   function automatic logic [31:0] exp_irq(logic [1:0] m, logic p, logic o, logic n, logic lvl);
      if (lvl) return {31'h0, m == 2'h0 && n == p};
      if (m == 2'h1) return {31'h0, o != n && n == p};
      return {31'h0, m == 2'h2 && o != n};
   endfunction
   function automatic logic [31:0] exp_b(logic [31:0] r);
      return {26'h0, r[12], r[9], r[8], r[2], r[1], r[0]};
   endfunction
   // ----
   // scenarios
   // ----
   task automatic reset_test();
      logic [31:0] ra [4] = '{ADDR_CTRL_A, ADDR_CTRL_B, ADDR_XBAR_A, 32'h4002A0F0};
      logic [31:0] re [4] = '{CTRL_A_RESET, CTRL_B_RESET, XBAR_RESET, 32'h0};
      for (int j = 0; j < 4; j++) begin
         rd(ra[j]);
         chk("reset_value", rv, re[j]);
      end
      chk("latch_reset", {16'h0, latch}, {16'h0, LATCH_RESET});
   endtask
   task automatic irq_test();
      logic [1:0] m;
      logic p, ch, en, o, n, lv;
      logic [3:0] sel;
      logic [31:0] c, cfg;
      for (int i = 0; i < 16; i++) begin
         {m, p, ch} = i[3:0];
         sel = 4'($random(seed));
         en = (i != 5);
         cfg = {25'h0, m, p, sel};
         wr(ADDR_CTRL_A, ch ? cfg << 8 : cfg);
         if (en) wr(ADDR_CTRL_A + OFS_SET, ch ? 32'h00008000 : 32'h00000080);
         repeat (8) @(posedge clk);
         o = tgt[{ch, sel}];
         for (int k = 0; k < 6; k++) begin
            @(posedge clk);
            #1 tgt = $random(seed);
            lag = 2'($random(seed));
            if (k == 0) tgt[{ch, sel}] = ~o;
            n = tgt[{ch, sel}];
            c = 32'h0;
            repeat (10) begin
               @(posedge clk);
               #1 c = c + {31'h0, ch ? irq_b : irq_a};
            end
            lv = ch ? irq_b : irq_a;
            chk("irq_level", {31'h0, lv}, {31'h0, en} & exp_irq(m, p, o, n, 1'b1));
            if (m != 2'h0) chk("irq_edges", c, {31'h0, en} & exp_irq(m, p, o, n, 1'b0));
            o = n;
         end
      end
   endtask
   task automatic pulse_test();
      wr(ADDR_PGMASK, 32'h000000FF);
      wr(ADDR_CTRL_A, 32'h14000000);
      wr(ADDR_PHASE, 32'h000500FF);
      rd(ADDR_CTRL_A);
      chk("done_busy", rv, 32'h14000000);
      wr(ADDR_LATCH, 32'h00005A00);
      @(posedge clk);
      #1 chk("latch_busy", {16'h0, latch}, 32'h00005AFF);
      repeat (30) @(posedge clk);
      #1 chk("latch_phase1", {16'h0, latch}, 32'h00005A05);
      rd(ADDR_CTRL_A);
      chk("done_set", rv, 32'h94000000);
      wr(ADDR_LATCH, 32'h0000A5F0);
      chk("latch_idle", {16'h0, latch}, 32'h0000A5F0);
   endtask
   task automatic lock_test();
      logic [31:0] r;
      wr(ADDR_CTRL_B, 32'h80000106);
      wr(ADDR_CTRL_B, 32'h00000000);
      wr(ADDR_XBAR_A, 32'h80000000);
      rd(ADDR_CTRL_B);
      chk("ctrl_b_locked", rv, 32'h80000106);
      chk("pinouts", {26'h0, lpt, pm, spi, swv, trc, scan}, exp_b(32'h106));
      chk("xbar_locked", {31'h0, xen}, 32'h0);
      for (int j = 0; j < 3; j++) begin
         if (j > 0) wr(ADDR_KEY, {24'h0, j == 1 ? KEY_FIRST : KEY_SECOND});
         rd(ADDR_KEY);
         chk("key_state", rv, j);
      end
      r = $random(seed);
      wr(ADDR_XBAR_A, r | 32'h80700000);
      rd(ADDR_XBAR_A);
      chk("xbar_value", rv, (r | 32'h80700000) & XBAR_RW_MASK);
      chk("xbar_outs", {8'h0, xen, ahb, adc, tmr, xlow}, {8'h0, 4'hF, r[19:0]});
      rd(ADDR_KEY);
      chk("key_relock", rv, 32'h0);
      wr(ADDR_XBAR_A, 32'h0);
      chk("xbar_refused", {31'h0, xen}, 32'h1);
      wr(ADDR_KEY, {24'h0, KEY_FIRST});
      wr(ADDR_KEY, {24'h0, KEY_SECOND});
      wr(ADDR_CTRL_B + OFS_CLR, 32'h80000000);
      r = $random(seed) & 32'h7FFFFFFF;
      wr(ADDR_CTRL_B, r);
      wr(ADDR_CTRL_B + OFS_SET, 32'h00001000);
      rd(ADDR_CTRL_B);
      chk("ctrl_b_open", rv, (r | 32'h1000) & CTRL_B_RW_MASK);
      chk("ctrl_b_outs", {26'h0, lpt, pm, spi, swv, trc, scan}, exp_b(r | 32'h1000));
      wr(ADDR_SKIP, r);
      chk("skip_open", {16'h0, skip}, {16'h0, r[15:0]});
      wr(ADDR_CTRL_B + OFS_SET, 32'h80000000);
      wr(ADDR_SKIP, ~r);
      chk("skip_locked", {16'h0, skip}, {16'h0, r[15:0]});
   endtask
   initial begin
      repeat (2) @(posedge clk);
      #1 rst_b = 1'b1;
      reset_test();
      $display("test reset done");
      irq_test();
      $display("test interrupts done");
      pulse_test();
      $display("test pulse done");
      lock_test();
      $display("test lock done");
      rst_b = 1'b0;
      repeat (2) @(posedge clk);
      #1 rst_b = 1'b1;
      reset_test();
      $display("test second reset done");
      end_of_test();
   end
endmodule // tb_top
`default_nettype wire
